/* File: src/acs_pkg.sv */
// package: register map, field layout and timing for the converter sequencer
// Summary of operation
// R01 - priority register bit 6 selects low (0) or high (1) converter interrupt priority
// R02 - software sets pin, reference, clock, enable, then channel before starting
// R03 - setting the start control begins a conversion on the selected channel
// R04 - completion sets the done flag; interrupt if enabled; flag stays until cleared
// R05 - each conversion leaves a 12-bit result for software in two registers
// R06 - repeat conversions need only start, wait, read; configuration is retained
// R07 - interrupt request persists while done flag set; software clears it
// R08 - software should clear the done flag before enabling the interrupt
// R09 - converter clock comes from the fixed internal fast oscillator, not system clock
// R10 - high register holds result bits 11..4, low register top nibble bits 3..0
// R11 - interrupt enable bit 6 blocks the completion interrupt at 0, permits at 1; code also raises irq at completion when mask bit 6 is 1
// R12 - a start while converting is ignored; the running conversion completes unchanged
package acs_pkg;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
   localparam logic [7:0] ADDR_PRIORITY = 8'hB8;
   localparam logic [7:0] ADDR_CONTROL = 8'hAA;
   localparam logic [7:0] ADDR_CLOCK_CFG = 8'hA9;
   localparam logic [7:0] ADDR_PIN_CFG0 = 8'hAB;
   localparam logic [7:0] ADDR_PIN_CFG1 = 8'hAC;
   localparam logic [7:0] ADDR_REF_CFG = 8'hAD;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'hAE;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'hAF;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hB0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hB1;
   localparam int BIT_CONV_IRQ = 6;
   localparam int BIT_START = 6;
   localparam int BIT_DONE = 4;
   localparam int BIT_ENABLE = 7;
   localparam logic [7:0] PRIORITY_MASK = 8'h6F;
   localparam logic [7:0] IRQ_ENABLE_MASK = 8'hEF;
   localparam logic [7:0] CONTROL_W_MASK = 8'h8F;
   localparam logic [7:0] CLOCK_CFG_MASK = 8'h07;
   localparam logic [7:0] PIN_CFG1_MASK = 8'h03;
   localparam logic [7:0] REF_CFG_MASK = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [11:0] RESULT_ZERO = 12'h000;
   // conversion length in converter clocks
   localparam logic [4:0] CONV_CLOCKS = 5'h10;
   // divider of the internal fast oscillator, one entry per clock select code
   localparam logic [5:0] DIV_TABLE [8] = '{6'h20, 6'h18, 6'h10, 6'h0C,
                                          6'h08, 6'h06, 6'h04, 6'h03};
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } acs_bus_t;
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_CONVERT = 2'b01
   } acs_state_t;
endpackage

/* File: src/acs_sequencer.sv */
// module: converter conversion sequencer with register port and interrupt
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
(
   input wire logic clk,
   input wire logic reset,
   input wire logic osc_tick,
   input wire acs_pkg::acs_bus_t bus,
   output logic [7:0] rdata,
   input wire logic [11:0] core_result,
   output logic core_sample,
   output logic [3:0] input_channel_select,
   output logic [2:0] conv_clock_select,
   output logic [9:0] analog_input_pin,
   output logic ref_select,
   output logic conv_enable,
   output logic converter_priority_select,
   output logic irq
);
   logic [7:0] priority_reg;
   logic [7:0] irq_enable;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [7:0] control;
   logic [7:0] pin_cfg0;
   logic [1:0] pin_cfg1;
   logic [11:0] result;
   logic conversion_done_flag;
   logic [5:0] div_count;
   logic [4:0] clk_count;
   logic tick_meta;
   logic tick_sync;
   logic tick_prev;
   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;

   ////////////////////////////////////////////////////////////////////
   // decode
   wire wr_irq_en = bus.wr && bus.addr == acs_pkg::ADDR_IRQ_ENABLE;
   wire wr_prio = bus.wr && bus.addr == acs_pkg::ADDR_PRIORITY;
   wire wr_ctrl = bus.wr && bus.addr == acs_pkg::ADDR_CONTROL;
   wire wr_clk = bus.wr && bus.addr == acs_pkg::ADDR_CLOCK_CFG;
   wire wr_pin0 = bus.wr && bus.addr == acs_pkg::ADDR_PIN_CFG0;
   wire wr_pin1 = bus.wr && bus.addr == acs_pkg::ADDR_PIN_CFG1;
   wire wr_ref = bus.wr && bus.addr == acs_pkg::ADDR_REF_CFG;
   wire wr_stat = bus.wr && bus.addr == acs_pkg::ADDR_IRQ_STATUS;
   wire wr_mask = bus.wr && bus.addr == acs_pkg::ADDR_IRQ_MASK;
   wire wr_rlow = bus.wr && bus.addr == acs_pkg::ADDR_RESULT_LOW;
   wire wr_rhigh = bus.wr && bus.addr == acs_pkg::ADDR_RESULT_HIGH;
   // start only honoured in idle with converter enabled
   wire start_req = wr_ctrl && bus.wdata[acs_pkg::BIT_START]; // see R03
   wire start_ok = start_req && state == acs_pkg::ACS_IDLE
                   && control[acs_pkg::BIT_ENABLE]; // see R12
   // converter clock paced by the internal oscillator tick, not the bus clock
   wire osc_edge = tick_sync && !tick_prev; // see R09
   wire [5:0] div_limit = acs_pkg::DIV_TABLE[conv_clock_select];
   wire conv_clock = osc_edge && div_count == div_limit - 6'h01;
   wire conv_end = state == acs_pkg::ACS_CONVERT && conv_clock
                   && clk_count == acs_pkg::CONV_CLOCKS - 5'h01;
   // hardware set beats software clear of the same cycle
   wire done_clear = wr_ctrl && !bus.wdata[acs_pkg::BIT_DONE];
   wire next_done = conv_end || (conversion_done_flag && !done_clear); // see R04
   logic [7:0] stat_set;
   wire [7:0] next_status = stat_set | (irq_status & ~(wr_stat ? bus.wdata : acs_pkg::BYTE_ZERO));
   // request held while flag set and enable bit on
   wire conv_irq_req = conversion_done_flag && irq_enable[acs_pkg::BIT_CONV_IRQ]; // see R07 R11
   wire next_irq = conv_irq_req || |(irq_status & irq_mask);
   wire [7:0] ctrl_rd = {control[7], state == acs_pkg::ACS_CONVERT, 1'b0,
                         conversion_done_flag, control[3:0]};
   wire [7:0] rd_mux =
      bus.addr == acs_pkg::ADDR_IRQ_ENABLE ? irq_enable :
      bus.addr == acs_pkg::ADDR_PRIORITY ? priority_reg :
      bus.addr == acs_pkg::ADDR_CONTROL ? ctrl_rd :
      bus.addr == acs_pkg::ADDR_CLOCK_CFG ? {5'h00, conv_clock_select} :
      bus.addr == acs_pkg::ADDR_PIN_CFG0 ? pin_cfg0 :
      bus.addr == acs_pkg::ADDR_PIN_CFG1 ? {6'h00, pin_cfg1} :
      bus.addr == acs_pkg::ADDR_REF_CFG ? {7'h00, ref_select} :
      bus.addr == acs_pkg::ADDR_RESULT_LOW ? {result[3:0], acs_pkg::NIBBLE_ZERO} : // see R10
      bus.addr == acs_pkg::ADDR_RESULT_HIGH ? result[11:4] : // see R05 R10
      bus.addr == acs_pkg::ADDR_IRQ_STATUS ? irq_status :
      bus.addr == acs_pkg::ADDR_IRQ_MASK ? irq_mask : acs_pkg::BYTE_ZERO;

   always_comb
   begin
      next_state = state;
      case (state)
         acs_pkg::ACS_IDLE: if (start_ok) next_state = acs_pkg::ACS_CONVERT;
         acs_pkg::ACS_CONVERT: if (conv_end) next_state = acs_pkg::ACS_IDLE;
         default: next_state = acs_pkg::ACS_IDLE;
      endcase
   end

   // status layout: only the conversion-end event is wired, other bits stay zero
   always_comb
   begin
      stat_set = acs_pkg::BYTE_ZERO;
      stat_set[acs_pkg::BIT_CONV_IRQ] = conv_end; // see R04
   end

   ////////////////////////////////////////////////////////////////////
   // oscillator tick crossing
   always_ff @(posedge clk)
   begin
      tick_meta <= osc_tick;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= acs_pkg::ACS_IDLE;
         div_count <= 6'h00;
         clk_count <= 5'h00;
      end
      else
      begin
         state <= next_state;
         if (start_ok || conv_clock)
            div_count <= 6'h00;
         else if (osc_edge)
            div_count <= div_count + 6'h01;
         if (start_ok)
            clk_count <= 5'h00;
         else if (conv_clock)
            clk_count <= clk_count + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   // configuration kept across conversions; only writes alter it
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         priority_reg <= acs_pkg::BYTE_ZERO;
         irq_enable <= acs_pkg::BYTE_ZERO;
         irq_mask <= acs_pkg::BYTE_ZERO;
      end
      else
      begin
         if (wr_prio) priority_reg <= bus.wdata & acs_pkg::PRIORITY_MASK; // see R01
         if (wr_irq_en) irq_enable <= bus.wdata & acs_pkg::IRQ_ENABLE_MASK; // see R11
         if (wr_mask) irq_mask <= bus.wdata;
      end
   end

   // channel frozen while converting; enable must already be set before a start
   always_ff @(posedge clk)
   begin
      if (reset)
         control <= acs_pkg::BYTE_ZERO;
      else if (wr_ctrl && state == acs_pkg::ACS_IDLE)
         control <= bus.wdata & acs_pkg::CONTROL_W_MASK; // see R06 R12
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         conv_clock_select <= 3'h0;
         pin_cfg0 <= acs_pkg::BYTE_ZERO;
         pin_cfg1 <= 2'h0;
         ref_select <= 1'b0;
      end
      else
      begin
         if (wr_clk) conv_clock_select <= bus.wdata[2:0] & acs_pkg::CLOCK_CFG_MASK[2:0];
         if (wr_pin0) pin_cfg0 <= bus.wdata;
         if (wr_pin1) pin_cfg1 <= bus.wdata[1:0] & acs_pkg::PIN_CFG1_MASK[1:0];
         if (wr_ref) ref_select <= bus.wdata[0] & acs_pkg::REF_CFG_MASK[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // result, flags and interrupt
   // core value taken only at the end edge; in between software may overwrite it
   always_ff @(posedge clk)
   begin
      if (reset)
         result <= acs_pkg::RESULT_ZERO;
      else if (conv_end)
         result <= core_result; // see R05
      else if (wr_rhigh)
         result[11:4] <= bus.wdata;
      else if (wr_rlow)
         result[3:0] <= bus.wdata[7:4];
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         conversion_done_flag <= 1'b0;
         irq_status <= acs_pkg::BYTE_ZERO;
         irq <= 1'b0;
      end
      else
      begin
         conversion_done_flag <= next_done; // see R04
         irq_status <= next_status;
         irq <= next_irq; // see R04 R07
      end
   end

   // read data only in the cycle after a read, zero otherwise
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rdata <= acs_pkg::BYTE_ZERO;
         core_sample <= 1'b0;
      end
      else
      begin
         rdata <= bus.rd ? rd_mux : acs_pkg::BYTE_ZERO;
         core_sample <= next_state == acs_pkg::ACS_CONVERT;
      end
   end

   assign input_channel_select = control[3:0];
   assign conv_enable = control[acs_pkg::BIT_ENABLE];
   assign analog_input_pin = {pin_cfg1, pin_cfg0};
   assign converter_priority_select = priority_reg[acs_pkg::BIT_CONV_IRQ]; // see R01
endmodule
`default_nettype wire

/* File: test/acs_core_model.sv */
// partner: analog core and fast oscillator stand-in
`timescale 1ns/1ps
`default_nettype none
module acs_core_model
(
   input wire logic core_sample,
   input wire logic [11:0] value,
   output logic osc_tick,
   output logic [11:0] core_result
);
   // slowed for sim, free running, unrelated to clk
   initial osc_tick = 1'b0;
   always #30 osc_tick = ~osc_tick;
   // output not valid outside a conversion: show the inverse
   assign core_result = core_sample ? value : ~value;
endmodule
`default_nettype wire

/* File: test/acs_sequencer_sva.sv */
// checker: port-level assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_sva
(
   input wire logic clk,
   input wire logic reset,
   input wire acs_pkg::acs_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic core_sample,
   input wire logic [3:0] input_channel_select,
   input wire logic converter_priority_select,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic ie6;
   logic mk6;
   wire ctl_wr = bus.wr && bus.addr == acs_pkg::ADDR_CONTROL;
   // shadow of the two enable bits, irq cannot be judged without them
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ie6 <= 1'b0;
         mk6 <= 1'b0;
      end
      else if (bus.wr)
      begin
         if (bus.addr == acs_pkg::ADDR_IRQ_ENABLE) ie6 <= bus.wdata[6];
         if (bus.addr == acs_pkg::ADDR_IRQ_MASK) mk6 <= bus.wdata[6];
      end
   end
   ////////////////////////////////////////
   AST_RD_IDLE: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_PRIO: assert property (bus.wr && bus.addr == acs_pkg::ADDR_PRIORITY
      |=> converter_priority_select == $past(bus.wdata[6])) else $error("priority bit");
   AST_START: assert property (ctl_wr && bus.wdata[7:6] == 2'b11 && !core_sample
      |=> core_sample) else $error("start not taken");
   AST_CHAN_SET: assert property (ctl_wr && !core_sample
      |=> input_channel_select == $past(bus.wdata[3:0])) else $error("channel not set");
   AST_CHAN_KEEP: assert property (ctl_wr && core_sample
      |=> $stable(input_channel_select)) else $error("channel changed while busy");
   AST_CONV_MIN: assert property ($rose(core_sample) |-> core_sample[*8])
      else $error("conversion cut short");
   AST_IRQ_RISE: assert property ($fell(core_sample) && (ie6 || mk6)
      |-> ##[0:2] irq) else $error("no interrupt at end");
   AST_IRQ_HOLD: assert property (irq && !$past(bus.wr) |=> irq)
      else $error("interrupt dropped");
   AST_IRQ_BLOCK: assert property (!ie6 && !mk6 |=> !irq)
      else $error("interrupt while disabled");
   cover property ($fell(core_sample) && ie6);
   cover property (irq && mk6 && !ie6);
   cover property (ctl_wr && core_sample);
endmodule
`default_nettype wire

/* File: test/tb_acs_sequencer.sv */
// testbench: register scenarios for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_acs_sequencer;
   logic clk = 1'b0;
   logic reset = 1'b1;
   acs_pkg::acs_bus_t bus = '0;
   logic [7:0] rdata;
   logic core_sample, osc_tick, irq, prio, rd_d = 1'b0;
   logic [11:0] core_result, value = 12'h000;
   logic [3:0] chan;
   logic [2:0] clksel;
   logic [9:0] pins;
   logic refsel, conv_en;
   logic [7:0] expq[$];
   logic [7:0] regs[7] = '{8'hA8, 8'hB8, 8'hAA, 8'hAE, 8'hAF, 8'hB0, 8'hC0};
   logic [31:0] seed = 32'h18;
   int fail_count = 0, num_checks = 0;
   always #12.5 clk = ~clk;
   acs_sequencer u_dut (.clk(clk), .reset(reset), .osc_tick(osc_tick), .bus(bus),
      .rdata(rdata), .core_result(core_result), .core_sample(core_sample),
      .input_channel_select(chan), .conv_clock_select(clksel), .analog_input_pin(pins),
      .ref_select(refsel), .conv_enable(conv_en), .converter_priority_select(prio),
      .irq(irq));
   acs_core_model u_core (.core_sample(core_sample), .value(value), .osc_tick(osc_tick),
      .core_result(core_result));
   ////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one bus assignment per edge, so back-to-back cycles never race
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: w, rd: r};
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      op(1'b0, 1'b1, a, 8'h00);
   endtask
   always @(posedge clk)
   begin
      if (rd_d) check(rdata, expq.pop_front());
      rd_d <= bus.rd;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      foreach (regs[k]) rd(regs[k], 8'h00);
      op(1'b1, 1'b0, 8'hAB, 8'hFF);
      op(1'b1, 1'b0, 8'hAC, 8'hFF);
      op(1'b1, 1'b0, 8'hAD, 8'h01);
      op(1'b1, 1'b0, 8'hA9, 8'h07);
      op(1'b1, 1'b0, 8'hAA, 8'h80);
      op(1'b1, 1'b0, 8'hB8, 8'hFF);
      rd(8'hB8, acs_pkg::PRIORITY_MASK);
      check({7'h00, prio}, 8'h01);
      check(pins[7:0], 8'hFF);
      check({6'h00, pins[9:8]}, 8'h03);
      check({5'h00, clksel}, 8'h07);
      check({6'h00, refsel, conv_en}, 8'h03);
      for (int i = 0; i < 3; i++)
      begin
         seed = xorshift(seed);
         value <= seed[11:0];
         op(1'b1, 1'b0, 8'hA8, (i == 0) ? 8'h40 : 8'h00);
         op(1'b1, 1'b0, 8'hB1, (i == 1) ? 8'h40 : 8'h00);
         op(1'b1, 1'b0, 8'hAA, {4'h8, seed[15:12]});
         op(1'b1, 1'b0, 8'hAA, {4'hC, seed[15:12]});
         op(1'b1, 1'b0, 8'hAA, {4'hC, ~seed[15:12]});
         op(1'b0, 1'b0, 8'h00, 8'h00);
         for (int n = 0; core_sample !== 1'b0; n++)
         begin
            if (n == 500)
            begin
               fail_count++;
               print_verdict();
            end
            @(posedge clk);
         end
         repeat (2) @(posedge clk);
         check({7'h00, irq}, (i < 2) ? 8'h01 : 8'h00);
         check({4'h0, chan}, {4'h0, seed[15:12]});
         rd(8'hAF, seed[11:4]);
         rd(8'hAE, {seed[3:0], 4'h0});
         rd(8'hAA, {4'h9, seed[15:12]});
         rd(8'hB0, 8'h40);
         op(1'b1, 1'b0, 8'hAA, {4'h8, seed[15:12]});
         op(1'b1, 1'b0, 8'hB0, 8'h40);
         op(1'b0, 1'b0, 8'h00, 8'h00);
         @(posedge clk);
         check({7'h00, irq}, 8'h00);
      end
      print_verdict();
   end
endmodule
bind acs_sequencer acs_sequencer_sva u_sva (.clk(clk), .reset(reset), .bus(bus),
   .rdata(rdata), .core_sample(core_sample), .input_channel_select(input_channel_select),
   .converter_priority_select(converter_priority_select), .irq(irq));
`default_nettype wire
